// file: bench/high_speed_pulse_counter_bench.sv
`timescale 1ns/1ns

module high_speed_pulse_counter_bench;
    import pulse_counter_pkg::*;
    typedef struct {
        count_mode_e mode;
        int op;
        int n;
        value_t exp0;
        value_t exp1;
    } row_s;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clock_enable = 1'b1;
    logic [8:0] pins;
    count_mode_e pair_mode [3];
    logic [5:0] group_enable, soft_reset, action_select, output_clear;
    logic [2:0] pin_reset_enable;
    value_t preset_value [6], reset_value [6], current_value [6];
    logic [5:0] match_output, interrupt_request;
    logic [2:0] plain_input;
    int n_errors = 0;
    int checks_done = 0;
    int hits;
    row_s rows [9];

    always #2 clock = ~clock;

    pulse_source u_pulse_source (.clock(clock), .pins(pins));

    pulse_counter #(.EXTENDED(1'b1), .LARGE(1'b1)) u_pulse_counter (
        .clock(clock), .reset(reset), .clock_enable(clock_enable),
        .ext_input_zero(pins[PIN_ZERO]), .ext_input_one(pins[PIN_ONE]),
        .ext_input_two(pins[PIN_TWO]), .ext_input_three(pins[PIN_THREE]),
        .ext_input_four(pins[PIN_FOUR]), .ext_input_five(pins[PIN_FIVE]),
        .ext_input_six(pins[PIN_SIX]), .ext_input_seven(pins[PIN_SEVEN]),
        .ext_input_thirteen(pins[PIN_THIRTEEN]), .pair_mode(pair_mode),
        .group_enable(group_enable), .pin_reset_enable(pin_reset_enable),
        .soft_reset(soft_reset), .action_select(action_select),
        .output_clear(output_clear), .preset_value(preset_value),
        .reset_value(reset_value), .current_value(current_value),
        .match_output(match_output), .interrupt_request(interrupt_request),
        .plain_input(plain_input));

    task automatic check(input value_t got, input value_t exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    task automatic load(input logic [5:0] g);
        @(negedge clock);
        soft_reset = g;
        @(negedge clock);
        soft_reset = 6'h00;
    endtask : load

    // bounded wait; a miss ends the run
    task automatic wait_match(input int g);
        int i;
        for (i = 0; i < 20 && match_output[g] !== 1'b1; i++)
            @(negedge clock);
        check(match_output[g], 1'b1);
        if (i == 20) results();
    endtask : wait_match

    task automatic count_irq(input int g, input int span);
        hits = 0;
        repeat (span) begin
            @(negedge clock);
            if (interrupt_request[g] === 1'b1) hits++;
        end
    endtask : count_irq

    initial begin
        pair_mode = '{MODE_ADDING, MODE_ADDING, MODE_ADDING};
        group_enable = 6'h3F;
        soft_reset = 6'h00;
        action_select = 6'h02;
        output_clear = 6'h00;
        pin_reset_enable = 3'h0;
        for (int g = 0; g < 6; g++) begin
            preset_value[g] = 32'hFFFF_FF00;
            reset_value[g] = 32'h0000_0010;
        end
        // ops: 0 pulse a, 1 pulse b, 2 a with b high, 3 quad up, 4 down
        rows = '{'{MODE_ADDING, 0, 3, 32'h13, 32'h10},
                 '{MODE_ADDING, 1, 2, 32'h10, 32'h12},
                 '{MODE_DIR_SELECT, 0, 2, 32'h12, 32'h10},
                 '{MODE_DIR_SELECT, 2, 3, 32'h0D, 32'h10},
                 '{MODE_DUAL_PULSE, 0, 2, 32'h12, 32'h10},
                 '{MODE_DUAL_PULSE, 1, 3, 32'h0D, 32'h10},
                 '{MODE_TWO_EDGE, 3, 2, 32'h14, 32'h10},
                 '{MODE_TWO_EDGE, 4, 2, 32'h0C, 32'h10},
                 '{MODE_FOUR_EDGE, 4, 2, 32'h08, 32'h10}};
        repeat (4) @(negedge clock);
        reset = 1'b0;
        check(current_value[0], VALUE_RESET);
        foreach (rows[r]) begin
            pair_mode[0] = rows[r].mode;
            load(6'h03);
            case (rows[r].op)
                0: u_pulse_source.pulse(PIN_ZERO, rows[r].n);
                1: u_pulse_source.pulse(PIN_ONE, rows[r].n);
                2: begin
                    u_pulse_source.set(PIN_ONE, 1'b1);
                    u_pulse_source.pulse(PIN_ZERO, rows[r].n);
                    u_pulse_source.set(PIN_ONE, 1'b0);
                end
                3: u_pulse_source.quad(PIN_ZERO, PIN_ONE, 1'b1, rows[r].n);
                default: u_pulse_source.quad(PIN_ZERO, PIN_ONE, 1'b0, rows[r].n);
            endcase
            idle(8);
            check(current_value[0], rows[r].exp0);
            check(current_value[1], rows[r].exp1);
        end
        pair_mode[0] = MODE_ADDING;
        preset_value[0] = 32'h11;
        preset_value[1] = 32'h11;
        load(6'h03);
        u_pulse_source.pulse(PIN_ZERO, 1);
        wait_match(0);
        fork
            u_pulse_source.pulse(PIN_ONE, 1);
            count_irq(1, 30);
        join
        check(value_t'(hits), 32'h1);
        check(match_output[1], 1'b0);
        output_clear = 6'h01;
        idle(1);
        output_clear = 6'h00;
        idle(2);
        check(match_output[0], 1'b0);
        // z pins of the first and middle pairs reload their groups' reset value
        pin_reset_enable = 3'h3;
        u_pulse_source.pulse(PIN_TWO, 1);
        u_pulse_source.pulse(PIN_THIRTEEN, 1);
        idle(8);
        check(current_value[0], 32'h10);
        check(current_value[2], 32'h10);
        pin_reset_enable = 3'h0;
        u_pulse_source.set(PIN_TWO, 1'b1);
        idle(4);
        check(plain_input[0], 1'b1);
        u_pulse_source.set(PIN_TWO, 1'b0);
        reset_value[2] = 32'hFFFF_FFFF;
        load(6'h04);
        u_pulse_source.pulse(PIN_THREE, 1);
        idle(8);
        check(current_value[2], 32'h0);
        // a pulse seen only while frozen must not count
        clock_enable = 1'b0;
        u_pulse_source.pulse(PIN_FOUR, 1);
        idle(4);
        clock_enable = 1'b1;
        idle(8);
        check(current_value[3], 32'h0);
        u_pulse_source.pulse(PIN_FOUR, 1);
        idle(8);
        check(current_value[3], 32'h1);
        reset = 1'b1;
        idle(1);
        reset = 1'b0;
        idle(1);
        for (int g = 0; g < 6; g++) begin
            check(current_value[g], VALUE_RESET);
        end
        check(value_t'(match_output), 32'h0);
        check(value_t'(interrupt_request), 32'h0);
        results();
    end
endmodule : high_speed_pulse_counter_bench

// file: bench/pulse_source.sv
`timescale 1ns/1ns

module pulse_source (
    input wire logic clock,
    output logic [8:0] pins
);
    initial pins = 9'h000;

    task automatic set(input int idx, input bit lvl);
        @(negedge clock);
        pins[idx] = lvl;
        repeat (3) @(negedge clock);
    endtask : set

    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            set(idx, 1'b1);
            set(idx, 1'b0);
        end
    endtask : pulse

    // a leads b to count up, b leads a to count down
    task automatic quad(input int a, input int b, input bit up, input int n);
        int first;
        int second;
        first = up ? a : b;
        second = up ? b : a;
        repeat (n) begin
            set(first, 1'b1);
            set(second, 1'b1);
            set(first, 1'b0);
            set(second, 1'b0);
        end
    endtask : quad
endmodule : pulse_source

// file: hw/count_channel.sv
`timescale 1ns/1ns

module count_channel (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic count_up,
    input wire logic count_down,
    input wire logic load,
    input wire pulse_counter_pkg::value_t reset_value,
    input wire pulse_counter_pkg::value_t preset_value,
    output pulse_counter_pkg::value_t current_value,
    output logic match_pulse
);
    import pulse_counter_pkg::*;

    value_t value_q;
    logic equal_q;
    logic match_q;
    logic equal_now;

    assign equal_now = (value_q == preset_value);
    assign current_value = value_q;
    assign match_pulse = match_q;

    // load reset value
    // load beats a step arriving in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            value_q <= VALUE_RESET;
        end else if (clock_enable) begin
            if (load) begin
                value_q <= reset_value;
            end else if (count_up && !count_down) begin
                value_q <= value_q + VALUE_STEP;
            end else if (count_down && !count_up) begin
                value_q <= value_q - VALUE_STEP;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            equal_q <= 1'b0;
            match_q <= 1'b0;
        end else if (clock_enable) begin
            equal_q <= equal_now;
            match_q <= equal_now && !equal_q;
        end
    end

    load_value_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && load |=> value_q == $past(reset_value))
        else $error("load did not take reset value");

    step_up_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && count_up && !count_down && !load
        |=> value_q == $past(value_q) + VALUE_STEP)
        else $error("up step missed");

    step_down_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && count_down && !count_up && !load
        |=> value_q == $past(value_q) - VALUE_STEP)
        else $error("down step missed");

    match_entry_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && equal_now && !equal_q |=> match_pulse)
        else $error("match not flagged on entry");

    match_once_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && match_pulse |=> !match_pulse)
        else $error("match repeated while equal");

endmodule : count_channel

// file: hw/pulse_counter.sv
`timescale 1ns/1ns

module pulse_counter #(
    parameter bit EXTENDED = 1'b0,
    parameter bit LARGE = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic ext_input_zero,
    input wire logic ext_input_one,
    input wire logic ext_input_two,
    input wire logic ext_input_three,
    input wire logic ext_input_four,
    input wire logic ext_input_five,
    input wire logic ext_input_six,
    input wire logic ext_input_seven,
    input wire logic ext_input_thirteen,
    input wire pulse_counter_pkg::count_mode_e pair_mode [3],
    input wire logic [5:0] group_enable,
    input wire logic [2:0] pin_reset_enable,
    input wire logic [5:0] soft_reset,
    input wire logic [5:0] action_select,
    input wire logic [5:0] output_clear,
    input wire pulse_counter_pkg::value_t preset_value [6],
    input wire pulse_counter_pkg::value_t reset_value [6],
    output pulse_counter_pkg::value_t current_value [6],
    output logic [5:0] match_output,
    output logic [5:0] interrupt_request,
    output logic [2:0] plain_input
);
    import pulse_counter_pkg::*;

    localparam int PIN_A [3] = '{PIN_ZERO, PIN_THREE, PIN_SIX};
    localparam int PIN_B [3] = '{PIN_ONE, PIN_FOUR, PIN_SEVEN};
    localparam int PIN_Z [3] = '{PIN_TWO, PIN_THIRTEEN, PIN_FIVE};

    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] meta_q;
    logic [PIN_COUNT-1:0] sync_q;
    logic [PIN_COUNT-1:0] prev_q;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic [5:0] step_up;
    logic [5:0] step_down;
    logic [5:0] load;
    logic [5:0] match_pulse;
    logic [5:0] match_output_q;
    logic [5:0] interrupt_q;
    logic [2:0] plain_q;
    logic [2:0] z_used;

    assign pins_raw = {ext_input_thirteen, ext_input_seven, ext_input_six,
        ext_input_five, ext_input_four, ext_input_three, ext_input_two,
        ext_input_one, ext_input_zero};

    // two-stage synchroniser
    // only the second stage feeds edge detection
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (clock_enable) begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    for (genvar p = 0; p < PAIR_COUNT; p++) begin : g_pair
        logic a_now;
        logic b_now;
        logic a_rise;
        logic a_fall;
        logic b_rise;
        logic b_fall;
        logic pair_allowed;
        logic two_phase;
        logic paired;
        logic quad_a_up;
        logic quad_a_dn;
        logic quad_b_up;
        logic quad_b_dn;
        logic odd_up;
        logic odd_dn;

        assign a_now = sync_q[PIN_A[p]];
        assign b_now = sync_q[PIN_B[p]];
        assign a_rise = rise[PIN_A[p]];
        assign a_fall = fall[PIN_A[p]];
        assign b_rise = rise[PIN_B[p]];
        assign b_fall = fall[PIN_B[p]];

        // middle pair stays single adding on base builds
        assign pair_allowed = (p != PAIR_MIDDLE) || EXTENDED;
        // pair style from the odd group's mode
        assign two_phase = pair_allowed &&
            (pair_mode[p] == MODE_TWO_EDGE || pair_mode[p] == MODE_FOUR_EDGE);
        assign paired = pair_allowed && (two_phase ||
            pair_mode[p] == MODE_DIR_SELECT ||
            pair_mode[p] == MODE_DUAL_PULSE);

        assign quad_a_up = (a_rise && !b_now) || (a_fall && b_now);
        assign quad_a_dn = (a_rise && b_now) || (a_fall && !b_now);
        assign quad_b_up = (b_rise && a_now) || (b_fall && !a_now);
        assign quad_b_dn = (b_rise && !a_now) || (b_fall && a_now);

        always_comb begin
            odd_up = a_rise;
            odd_dn = 1'b0;
            if (pair_allowed) begin
                case (pair_mode[p])
                    MODE_DIR_SELECT: begin
                        odd_up = a_rise && !b_now;
                        odd_dn = a_rise && b_now;
                    end
                    // simultaneous up and down pulses cancel
                    MODE_DUAL_PULSE: begin
                        odd_up = a_rise && !b_rise;
                        odd_dn = b_rise && !a_rise;
                    end
                    // a on the first pin, b on the second
                    MODE_TWO_EDGE: begin
                        odd_up = quad_a_up;
                        odd_dn = quad_a_dn;
                    end
                    MODE_FOUR_EDGE: begin
                        odd_up = quad_a_up || quad_b_up;
                        odd_dn = quad_a_dn || quad_b_dn;
                    end
                    default: begin
                        odd_up = a_rise;
                        odd_dn = 1'b0;
                    end
                endcase
            end
        end

        // steps reach only the counters whose group_enable bit is set
        assign step_up[2*p] = group_enable[2*p] && odd_up;
        assign step_down[2*p] = group_enable[2*p] && odd_dn;
        assign step_up[2*p+1] = group_enable[2*p+1] && !paired && b_rise;
        assign step_down[2*p+1] = 1'b0;

        // thirteen pin only on the large build
        assign z_used[p] = pin_reset_enable[p] &&
            ((p != PAIR_MIDDLE) || LARGE);

        // soft or pin reset loads the odd group
        assign load[2*p] = soft_reset[2*p] || (z_used[p] && rise[PIN_Z[p]]);
        assign load[2*p+1] = soft_reset[2*p+1];

        // unused reset pin reads as a plain input
        always_ff @(posedge clock) begin
            if (reset) begin
                plain_q[p] <= 1'b0;
            end else if (clock_enable) begin
                plain_q[p] <= z_used[p] ? 1'b0 : sync_q[PIN_Z[p]];
            end
        end

        plain_hold_a: assert property (@(posedge clock) disable iff (reset)
            clock_enable && z_used[p] |=> !plain_input[p])
            else $error("reset pin leaked as plain input");

        quad_dir_a: assert property (@(posedge clock) disable iff (reset)
            group_enable[2*p] && pair_allowed && !soft_reset[2*p] &&
            pair_mode[p] == MODE_TWO_EDGE && a_rise && !b_now
            |-> step_up[2*p] && !step_down[2*p])
            else $error("quadrature direction wrong");
    end

    for (genvar g = 0; g < GROUP_COUNT; g++) begin : g_group
        count_channel u_channel (
            .clock(clock),
            .reset(reset),
            .clock_enable(clock_enable),
            .count_up(step_up[g]),
            .count_down(step_down[g]),
            .load(load[g]),
            .reset_value(reset_value[g]),
            .preset_value(preset_value[g]),
            .current_value(current_value[g]),
            .match_pulse(match_pulse[g])
        );
    end

    // match with its action_select bit clear turns on output, set wins over clear
    always_ff @(posedge clock) begin
        if (reset) begin
            match_output_q <= '0;
        end else if (clock_enable) begin
            match_output_q <= (match_output_q & ~output_clear) |
                (match_pulse & ~action_select);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            interrupt_q <= '0;
        end else if (clock_enable) begin
            interrupt_q <= match_pulse & action_select;
        end
    end

    assign match_output = match_output_q;
    assign interrupt_request = interrupt_q;
    assign plain_input = plain_q;

    sync_depth_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable ##1 clock_enable |=> sync_q == $past(pins_raw, 2))
        else $error("pin synchroniser depth wrong");

    out_set_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && match_pulse[0] && action_select[0] == ACTION_OUTPUT
        |=> match_output[0])
        else $error("output not set on match");

    irq_fire_a: assert property (@(posedge clock) disable iff (reset)
        clock_enable && match_pulse[1] && action_select[1] == ACTION_INTERRUPT
        |=> interrupt_request[1])
        else $error("interrupt not raised on match");

    frozen_state_a: assert property (@(posedge clock) disable iff (reset)
        !clock_enable |=> $stable(current_value[0]) && $stable(match_output))
        else $error("state moved while disabled");

endmodule : pulse_counter

// file: hw/pulse_counter_pkg.sv
package pulse_counter_pkg;

    localparam int GROUP_COUNT = 6;
    localparam int PAIR_COUNT = 3;
    localparam int VALUE_WIDTH = 32;
    localparam int PIN_COUNT = 9;

    // index of each pin in the synchronised pin vector
    localparam int PIN_ZERO = 0;
    localparam int PIN_ONE = 1;
    localparam int PIN_TWO = 2;
    localparam int PIN_THREE = 3;
    localparam int PIN_FOUR = 4;
    localparam int PIN_FIVE = 5;
    localparam int PIN_SIX = 6;
    localparam int PIN_SEVEN = 7;
    localparam int PIN_THIRTEEN = 8;

    // the pair whose reset pin only the larger variant has
    localparam int PAIR_MIDDLE = 1;

    typedef logic [VALUE_WIDTH-1:0] value_t;

    localparam value_t VALUE_RESET = 32'h0000_0000;
    localparam value_t VALUE_STEP = 32'h0000_0001;

    typedef enum logic [2:0] {
        MODE_ADDING = 3'h0,
        MODE_DIR_SELECT = 3'h1,
        MODE_DUAL_PULSE = 3'h2,
        MODE_TWO_EDGE = 3'h3,
        MODE_FOUR_EDGE = 3'h4
    } count_mode_e;

    localparam logic ACTION_OUTPUT = 1'b0;
    localparam logic ACTION_INTERRUPT = 1'b1;

endpackage : pulse_counter_pkg
